// [logic/adc_cmd_pkg.sv]
// What this block does
// - Frame starts on qualified chip-select fall or sync rise
// - Sample input on falling, shift output on rising
// - Frame start enables input, output and clock path
// - First four input bits form the command code
// - Top four output bits shift out meanwhile
// - Next twelve bits load config only on write
// - Config word held during automatic power-down
// - Clock may pause after eight bits, then resume
// - Input ignored after sixteen bits or chip-select rise
// - Conversion and FIFO reads shift out twelve more bits
// - Output released after sixteen bits or chip-select rise
// - Conversion commands pick source, then start conversion
// - Codes 0-7 pick channels; four-channel part aliases
// - Code Ah writes config and clears FIFO
// - Codes B-D pick midpoint, low, high test voltages
// - Code Eh shows FIFO head on output
// - Code Fh loads config with 800h
// - Result is left-aligned; low bits are zero
package adc_cmd_pkg;

	// ==========================================
	// Frame geometry
	localparam int unsigned WORD_BITS    = 16;
	localparam int unsigned CMD_BITS     = 4;
	localparam int unsigned CFG_BITS     = 12;
	localparam logic [4:0]  CNT_CMD_DONE = 5'h04;
	localparam logic [4:0]  CNT_PAUSE    = 5'h08;
	localparam logic [4:0]  CNT_END      = 5'h10;

	// ==========================================
	// Command codes
	localparam logic [3:0] CMD_CHAN_LAST   = 4'h7;
	localparam logic [3:0] CMD_CONFIG_WR   = 4'ha;
	localparam logic [3:0] CMD_TEST_MID    = 4'hb;
	localparam logic [3:0] CMD_TEST_LOW    = 4'hc;
	localparam logic [3:0] CMD_TEST_HIGH   = 4'hd;
	localparam logic [3:0] CMD_FIFO_READ   = 4'he;
	localparam logic [3:0] CMD_FACTORY     = 4'hf;

	// ==========================================
	// Configuration word layout and values
	localparam logic [11:0] CFG_RESET      = 12'h000;
	localparam logic [11:0] CFG_FACTORY    = 12'h800;
	localparam int unsigned CFG_FORMAT_BIT = 10;
	localparam int unsigned CFG_SAMPLE_BIT = 9;
	localparam int unsigned CFG_CLOCK_BIT  = 8;

	// ==========================================
	// Analog source selection
	typedef enum logic [1:0] {
		SRC_CHANNEL   = 2'h0,
		SRC_TEST_MID  = 2'h1,
		SRC_TEST_LOW  = 2'h2,
		SRC_TEST_HIGH = 2'h3
	} source_kind_type;

	typedef struct packed {
		source_kind_type kind;     // Channel or test voltage
		logic [2:0]      channel;  // Channel number when kind is channel
	} conv_request_type;

	typedef struct packed {
		logic        twos_complement;  // Result code format
		logic        short_sampling;   // Short sampling length
		logic        sclk_conv_clock;  // Conversion clock source
		logic [11:0] word;             // Whole configuration word
	} config_view_type;

endpackage

// [logic/adc_serial_command_decoder.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Result FIFO
module result_fifo #(
	parameter int unsigned WIDTH = 14,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage array
	logic [AW-1:0]    wr_ptr_ff;       // Write index
	logic [AW-1:0]    rd_ptr_ff;       // Read index
	logic [AW:0]      count_ff;        // Words held
	logic             push;
	logic             pop;

	// Full at DEPTH words; occupancy is one bit wider so the count never wraps
	assign in_ready  = (count_ff != (AW+1)'(DEPTH)) && !flush;
	assign out_valid = (count_ff != '0);
	assign out_data  = mem_ff[rd_ptr_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready && !flush;

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk_sys) begin
		if (!rst_b || flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ==========================================
// Serial command front end
module adc_serial_command_decoder
	import adc_cmd_pkg::*;
#(
	parameter int unsigned RESULT_BITS = 14,  // 14 or 12
	parameter int unsigned CHANNELS    = 8,   // 8 or 4
	parameter int unsigned FIFO_DEPTH  = 32
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_b,
	input  wire logic                   cs_b,
	input  wire logic                   frame_sync,
	input  wire logic                   sclk,
	input  wire logic                   serial_in,
	output logic                        serial_out,
	output logic                        serial_out_oe,
	input  wire logic                   auto_power_down,
	input  wire logic [RESULT_BITS-1:0] result_data,
	input  wire logic                   result_valid,
	output logic                        result_ready,
	output logic                        conv_start,
	output conv_request_type            conv_request,
	output config_view_type             config_view
);

	// ==========================================
	// Pin synchronisers, then one delay stage for edges
	logic [1:0] cs_sync_ff;
	logic [1:0] fs_sync_ff;
	logic [1:0] sclk_sync_ff;
	logic [1:0] sdi_sync_ff;
	logic       cs_prev_ff;    // Previous synced chip select
	logic       fs_prev_ff;    // Previous synced frame sync
	logic       sclk_prev_ff;  // Previous synced serial clock

	// Two flops per pin, second stage only is read
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cs_sync_ff   <= 2'h3;
			fs_sync_ff   <= 2'h3;  // High so a tied-high sync gives no edge after reset
			sclk_sync_ff <= 2'h0;
			sdi_sync_ff  <= 2'h0;
		end else begin
			cs_sync_ff   <= {cs_sync_ff[0], cs_b};
			fs_sync_ff   <= {fs_sync_ff[0], frame_sync};
			sclk_sync_ff <= {sclk_sync_ff[0], sclk};
			sdi_sync_ff  <= {sdi_sync_ff[0], serial_in};
		end
	end

	// Edge history
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cs_prev_ff   <= 1'b1;
			fs_prev_ff   <= 1'b1;
			sclk_prev_ff <= 1'b0;
		end else begin
			cs_prev_ff   <= cs_sync_ff[1];
			fs_prev_ff   <= fs_sync_ff[1];
			sclk_prev_ff <= sclk_sync_ff[1];
		end
	end

	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic fs_rise;
	logic sclk_fall;
	logic sclk_rise;

	assign cs_low    = !cs_sync_ff[1];
	assign cs_fall   = cs_prev_ff && !cs_sync_ff[1];
	assign cs_rise   = !cs_prev_ff && cs_sync_ff[1];
	assign fs_rise   = !fs_prev_ff && fs_sync_ff[1];
	assign sclk_fall = sclk_prev_ff && !sclk_sync_ff[1];
	assign sclk_rise = !sclk_prev_ff && sclk_sync_ff[1];

	// ==========================================
	// Frame state machine
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ARMED = 3'b010,
		ST_SHIFT = 3'b100
	} frame_state_type;

	frame_state_type state_ff;
	frame_state_type nxt_state;
	logic            frame_start;

	// Start on qualified chip-select fall, else wait for sync rise
	always_comb begin
		nxt_state   = state_ff;
		frame_start = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (cs_fall && fs_sync_ff[1]) begin
					nxt_state   = ST_SHIFT;
					frame_start = 1'b1;
				end else if (cs_fall) begin
					nxt_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (!cs_low) begin
					nxt_state = ST_IDLE;
				end else if (fs_rise) begin
					nxt_state   = ST_SHIFT;
					frame_start = 1'b1;
				end
			end
			ST_SHIFT: begin
				if (!cs_low) begin
					nxt_state = ST_IDLE;
				end else if (fs_rise) begin
					frame_start = 1'b1;  // Fresh frame restarts counter
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================
	// Bit counter and input shifter
	logic [4:0]  bit_cnt_ff;   // Falling edges seen this frame
	logic [15:0] in_shift_ff;  // Received input word bits
	logic [3:0]  cmd_ff;       // Latched command code
	logic        shifting;     // Path enabled and not yet done

	assign shifting = (state_ff == ST_SHIFT) && cs_low && (bit_cnt_ff != CNT_END);

	// Count and sample on falling serial clock; a pause just holds
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			bit_cnt_ff  <= '0;
			in_shift_ff <= '0;
		end else if (frame_start) begin
			bit_cnt_ff <= '0;
		end else if (shifting && sclk_fall) begin
			bit_cnt_ff  <= bit_cnt_ff + 5'h01;
			in_shift_ff <= {in_shift_ff[14:0], sdi_sync_ff[1]};
		end
	end

	logic cmd_done;  // Fourth falling edge this cycle
	logic word_done; // Sixteenth falling edge this cycle

	assign cmd_done  = shifting && sclk_fall && (bit_cnt_ff == CNT_CMD_DONE - 5'h01);
	assign word_done = shifting && sclk_fall && (bit_cnt_ff == CNT_END - 5'h01);

	// Command latch after the command nibble
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cmd_ff <= '0;
		end else if (cmd_done) begin
			cmd_ff <= {in_shift_ff[2:0], sdi_sync_ff[1]};
		end
	end

	logic [3:0] cmd_now;
	assign cmd_now = {in_shift_ff[2:0], sdi_sync_ff[1]};

	// ==========================================
	// Configuration word
	logic [11:0] config_ff;

	// Load on write or factory command, frozen in power-down
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			config_ff <= CFG_RESET;
		end else if (!auto_power_down) begin
			if (cmd_done && cmd_now == CMD_FACTORY) begin
				config_ff <= CFG_FACTORY;
			end else if (word_done && cmd_ff == CMD_CONFIG_WR) begin
				config_ff <= {in_shift_ff[10:0], sdi_sync_ff[1]};
			end
		end
	end

	// Decoded configuration fields
	always_comb begin
		config_view.twos_complement = config_ff[CFG_FORMAT_BIT];
		config_view.short_sampling  = config_ff[CFG_SAMPLE_BIT];
		config_view.sclk_conv_clock = config_ff[CFG_CLOCK_BIT];
		config_view.word            = config_ff;
	end

	// ==========================================
	// Source select and conversion start
	conv_request_type nxt_request;
	logic             is_convert;

	// Map command to analog source
	always_comb begin
		nxt_request.kind    = SRC_CHANNEL;
		nxt_request.channel = (CHANNELS == 4) ? {1'b0, cmd_now[1:0]} : cmd_now[2:0];
		is_convert          = 1'b1;
		case (cmd_now)
			CMD_TEST_MID: begin
				nxt_request.kind = SRC_TEST_MID;
			end
			CMD_TEST_LOW: begin
				nxt_request.kind = SRC_TEST_LOW;
			end
			CMD_TEST_HIGH: begin
				nxt_request.kind = SRC_TEST_HIGH;
			end
			default: begin
				is_convert = (cmd_now <= CMD_CHAN_LAST);
			end
		endcase
	end

	// Source is latched with the start pulse
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			conv_request <= '0;
			conv_start   <= 1'b0;
		end else begin
			conv_start <= cmd_done && is_convert;
			if (cmd_done && is_convert) begin
				conv_request <= nxt_request;
			end
		end
	end

	// ==========================================
	// Result path
	logic [RESULT_BITS-1:0] fifo_head;
	logic                   fifo_valid;
	logic                   fifo_pop;
	logic                   fifo_flush;
	logic [RESULT_BITS-1:0] last_result_ff;  // Previous conversion

	assign fifo_flush = cmd_done && (cmd_now == CMD_CONFIG_WR);
	assign fifo_pop   = cmd_done && (cmd_now == CMD_FIFO_READ);

	result_fifo #(
		.WIDTH (RESULT_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.flush     (fifo_flush),
		.in_data   (result_data),
		.in_valid  (result_valid),
		.in_ready  (result_ready),
		.out_data  (fifo_head),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// Keep the latest accepted result
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			last_result_ff <= '0;
		end else if (result_valid && result_ready) begin
			last_result_ff <= result_data;
		end
	end

	// ==========================================
	// Output shifter
	logic [15:0]            out_shift_ff;  // Output word bits
	logic                   oe_ff;         // Serial output driven
	logic [RESULT_BITS-1:0] pick;
	logic [RESULT_BITS-1:0] coded;

	// FIFO head when present, else previous result, in chosen format
	assign pick  = fifo_valid ? fifo_head : last_result_ff;
	assign coded = config_ff[CFG_FORMAT_BIT] ? {~pick[RESULT_BITS-1], pick[RESULT_BITS-2:0]} : pick;

	// Load at start so bit 15 is valid before first fall; shift on rise
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			out_shift_ff <= '0;
		end else if (frame_start) begin
			out_shift_ff <= {coded, (WORD_BITS - RESULT_BITS)'(0)};
		end else if (shifting && sclk_rise && bit_cnt_ff != 5'h00) begin
			out_shift_ff <= {out_shift_ff[14:0], 1'b0};
		end
	end

	// Drive from frame start until sixteenth fall or chip-select rise
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			oe_ff <= 1'b0;
		end else if (frame_start) begin
			oe_ff <= 1'b1;
		end else if (word_done || !cs_low) begin
			oe_ff <= 1'b0;
		end
	end

	assign serial_out    = out_shift_ff[15];
	assign serial_out_oe = oe_ff;

endmodule

`default_nettype wire

// [test/adc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Host serial port, sclk idle low
module adc_host_model (
	input  wire logic clk_sys,
	input  wire logic serial_out,
	output logic      cs_b,
	output logic      frame_sync,
	output logic      sclk,
	output logic      serial_in
);
	// Idle levels
	initial begin
		cs_b = 1'b1;
		frame_sync = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b1;
	end

	// One frame of n clocks, optional stall after eight bits
	task automatic frame(input logic [15:0] w, input int n, input logic by_fs, input int pause,
		output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge clk_sys);
		frame_sync = !by_fs;
		cs_b = 1'b0;
		if (by_fs) begin
			repeat (4) @(negedge clk_sys);
			frame_sync = 1'b1;
		end
		repeat (6) @(negedge clk_sys);
		for (int i = 0; i < n; i++) begin
			if (i == 8) repeat (pause) @(negedge clk_sys);
			repeat (4) @(negedge clk_sys);
			sclk = 1'b1;
			// Data changes on the rise and stands across the fall; extra bits toggle
			serial_in = (i < 16) ? w[15 - i] : !serial_in;
			repeat (4) @(negedge clk_sys);
			// Output bit has settled by now; take it just before the fall
			if (i < 16) rd[15 - i] = serial_out;
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk_sys);
		cs_b = 1'b1;
		frame_sync = 1'b1;
		serial_in = !serial_in;
		repeat (8) @(negedge clk_sys);
	endtask
endmodule

`default_nettype wire

// [test/adc_serial_command_decoder_chk.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Port checker
module adc_decoder_chk
	import adc_cmd_pkg::*;
#(
	parameter int unsigned CHANNELS = 8
) (
	input wire logic             clk_sys,
	input wire logic             rst_b,
	input wire logic             cs_b,
	input wire logic             frame_sync,
	input wire logic             serial_out_oe,
	input wire logic             auto_power_down,
	input wire logic             conv_start,
	input wire conv_request_type conv_request,
	input wire config_view_type  config_view
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("conversion start too long");
	a_req_with_start: assert property ($changed(conv_request) |-> conv_start)
		else $error("request changed without start");
	a_chan_range: assert property (conv_start && conv_request.kind == SRC_CHANNEL |->
		conv_request.channel < CHANNELS) else $error("channel out of range");
	a_oe_cs_high: assert property (cs_b[*7] |-> !serial_out_oe)
		else $error("output driven while deselected");
	a_oe_at_start: assert property (($fell(cs_b) && frame_sync) || ($rose(frame_sync) && !cs_b)
		|-> ##[3:6] serial_out_oe) else $error("output not enabled");
	a_cfg_pd_hold: assert property (auto_power_down ##1 auto_power_down |=> $stable(config_view.word))
		else $error("config changed in power-down");
	a_view_fields: assert property (config_view.twos_complement == config_view.word[10] &&
		config_view.short_sampling == config_view.word[9] && config_view.sclk_conv_clock == config_view.word[8])
		else $error("config view fields wrong");
	a_cfg_idle: assert property (cs_b[*8] |=> $stable(config_view.word))
		else $error("config changed between frames");
endmodule

bind adc_serial_command_decoder adc_decoder_chk #(.CHANNELS(CHANNELS)) i_adc_decoder_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .frame_sync(frame_sync),
	.serial_out_oe(serial_out_oe), .auto_power_down(auto_power_down), .conv_start(conv_start),
	.conv_request(conv_request), .config_view(config_view));

`default_nettype wire

// [test/test_adc_serial_command_decoder.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t got %h expected %h", $time, a, b); end end

// ==========================================
// Self-checking bench
module test_adc_serial_command_decoder;
	import adc_cmd_pkg::*;
	logic             clk_sys = 1'b0;
	logic             rst_b, cs_b, frame_sync, sclk, serial_in, serial_out, serial_out_oe;
	logic             auto_power_down, result_valid, result_ready, conv_start;
	logic [13:0]      result_data, last_res;   // Last accepted result
	logic [13:0]      q[$];                   // FIFO image
	logic [11:0]      cfg;                    // Config image
	conv_request_type conv_request, last_req;
	config_view_type  config_view;
	int               bad_count, total_checks;
	int               starts = 0;             // Start pulses seen

	always #10 clk_sys = ~clk_sys;

	adc_serial_command_decoder i_adc_serial_command_decoder (.clk_sys(clk_sys), .rst_b(rst_b),
		.cs_b(cs_b), .frame_sync(frame_sync), .sclk(sclk), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .auto_power_down(auto_power_down),
		.result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
		.conv_start(conv_start), .conv_request(conv_request), .config_view(config_view));
	adc_host_model i_adc_host_model (.clk_sys(clk_sys), .serial_out(serial_out), .cs_b(cs_b),
		.frame_sync(frame_sync), .sclk(sclk), .serial_in(serial_in));

	// Record start pulses
	always @(posedge clk_sys) begin
		if (conv_start === 1'b1) begin
			starts <= starts + 1;
			last_req <= conv_request;
		end
	end

	// Left-aligned word, sign bit flipped for two's complement
	function automatic logic [15:0] exp_word(input logic [13:0] r, input logic fmt);
		return {r[13] ^ fmt, r[12:0], 2'b00};
	endfunction

	// Offer one result, note it if taken
	task automatic push(input logic [13:0] d);
		@(negedge clk_sys);
		result_data = d;
		result_valid = 1'b1;
		if (result_ready === 1'b1) begin
			q.push_back(d);
			last_res = d;
		end
		@(negedge clk_sys);
		result_valid = 1'b0;
	endtask

	// One command frame with its checks
	task automatic run(input logic [3:0] c, input int n, input logic psh);
		logic [11:0] d;
		logic [15:0] rd, ex;
		int          s0;
		d = {1'b1, 11'($urandom)};
		auto_power_down = ($urandom % 4) == 0;
		if (psh) push(14'($urandom));
		ex = exp_word((q.size() > 0) ? q[0] : last_res, cfg[10]);
		s0 = starts;
		i_adc_host_model.frame({c, d}, n, 1'($urandom), ($urandom % 2) * 40, rd);
		if (c <= 4'h7 || (c >= 4'hb && c <= 4'hd)) begin
			`CHK(starts, s0 + 1)
			`CHK(last_req.kind, source_kind_type'((c <= 4'h7) ? 2'h0 : 2'(c - 4'ha)))
			if (c <= 4'h7) `CHK(last_req.channel, c[2:0])
		end else `CHK(starts, s0)
		if (c == 4'he && q.size() > 0) void'(q.pop_front());
		if (c == 4'ha) q.delete();
		if (!auto_power_down && n >= 16 && c == 4'ha) cfg = d;
		if (!auto_power_down && c == 4'hf) cfg = CFG_FACTORY;
		`CHK(config_view.word, cfg)
		if (n >= 16 && c != 4'h8 && c != 4'h9 && c != 4'ha && c != 4'hf) `CHK(rd, ex)
		auto_power_down = 1'b0;
	endtask

	// Verdict
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		#1500000;
		bad_count++;
		results();
	end

	// Main sequence
	initial begin
		rst_b = 1'b0;
		auto_power_down = 1'b0;
		result_valid = 1'b0;
		result_data = 14'h0000;
		last_res = 14'h0000;
		cfg = CFG_RESET;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(32'hfff625c2));
		repeat (12) @(negedge clk_sys);
		rst_b = 1'b1;
		`CHK(config_view.word, CFG_RESET)
		`CHK(serial_out_oe, 1'b0)
		repeat (6) @(negedge clk_sys);
		for (int c = 0; c < 16; c++) run(4'(c), 16, 1'b1);
		$display("test all_codes done");
		repeat (40) run(4'($urandom), 8 + 5 * ($urandom % 3), 1'b1);
		$display("test random_frames done");
		run(CMD_CONFIG_WR, 16, 1'b0);
		repeat (34) push(14'($urandom));
		`CHK(q.size(), 32)
		`CHK(result_ready, 1'b0)
		repeat (33) run(CMD_FIFO_READ, 16, 1'b0);
		`CHK(result_ready, 1'b1)
		$display("test fifo_fill_drain done");
		results();
	end
endmodule

`default_nettype wire
